// *** pkg/pmc_pkg.sv ***
package pmc_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [11:0] PMC_ADDR_W_MSB_DUMMY = 12'h000;
    localparam logic [11:0] PMC_CTL_OFFSET       = 12'h014;

    // field positions of power_management_control
    localparam int PMC_REF_WAIT_DIS_BIT   = 15;
    localparam int PMC_CRYSTAL_SUSPEND_DISABLE_BIT  = 14;
    localparam int PMC_EEE_WAKE_EN_BIT    = 13;
    localparam int PMC_EEE_WAKE_STS_BIT   = 12;
    localparam int PMC_MAC_SOFT_RST_BIT   = 11;
    localparam int PMC_RES_CLR_STS_BIT    = 9;
    localparam int PMC_RES_CLR_EN_BIT     = 8;
    localparam int PMC_DEV_READY_BIT      = 7;

    // values after reset
    localparam logic PMC_REF_WAIT_DIS_RST  = 1'b0;
    localparam logic PMC_CRYSTAL_SUSPEND_DISABLE_RST = 1'b0;
    localparam logic PMC_EEE_WAKE_EN_RST   = 1'b0;
    localparam logic PMC_EEE_WAKE_STS_RST  = 1'b0;
    localparam logic PMC_MAC_SOFT_RST_RST  = 1'b0;
    localparam logic PMC_RES_CLR_STS_RST   = 1'b0;
    localparam logic PMC_RES_CLR_EN_RST    = 1'b1;
    localparam logic PMC_DEV_READY_RST     = 1'b0;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int PMC_CLK_CYCLES_PER_MS = 100000;
    localparam int PMC_NETWORK_PHY_RESET_MIN_MS    = 4;
    localparam int PMC_NETWORK_PHY_RESET_EXT_MS    = 128;
    localparam int PMC_REF_SETTLE_MS     = 100;
    localparam int PMC_NETWORK_PHY_RESET_MIN_CYC   = PMC_NETWORK_PHY_RESET_MIN_MS * PMC_CLK_CYCLES_PER_MS;
    localparam int PMC_NETWORK_PHY_RESET_EXT_CYC   = PMC_NETWORK_PHY_RESET_EXT_MS * PMC_CLK_CYCLES_PER_MS;
    localparam int PMC_REF_SETTLE_CYC    = PMC_REF_SETTLE_MS * PMC_CLK_CYCLES_PER_MS;
    localparam int PMC_PHY_CNT_W         = 24;

endpackage

// *** rtl/pmc_power_mgmt_control.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - Reference-wait-disable set keeps analog reference on during PHY reset.
// - Reference-wait-disable and crystal-suspend-disable survive system resets under reset protection; power-on reset clears them.
// - Crystal-suspend-disable set keeps oscillator running in deep suspend and state_a.
// - EEE wake enable lets EEE wake status act as a wakeup event.
// - Remote resume completion clears EEE wake enable when resume-clears-enables set.
// - EEE activity sets EEE wake status regardless of its enable.
// - EEE wake status readable; software clears it by writing one.
// - MAC soft reset bit holds MAC receive and transmit domains in reset.
// - MAC domain resets release only when their clocks are running.
// - Remote resume with resume-clears-status clears listed wake status flags.
// - Same resume also clears general wake status bit 1 and EEE status.
// - Host-initiated resumes leave every wake status unchanged.
// - Resume-clears-status clear keeps all wake statuses after any resume.
// - Remote resume with resume-clears-enables clears all wake enables; resets to one.
// - Host-initiated resumes never clear wake enables.
// - Read-only device ready shows one only when ready; resets to zero.
// - PHY reset held at least 4 ms, stretched to 128 ms by reference wait.
// - Device ready stays low during PHY reset and configuration loading.
module pmc_power_mgmt_control
    import pmc_pkg::*;
#(
    parameter int unsigned NETWORK_PHY_RESET_MIN_CYCLES = PMC_NETWORK_PHY_RESET_MIN_CYC,
    parameter int unsigned NETWORK_PHY_RESET_EXT_CYCLES = PMC_NETWORK_PHY_RESET_EXT_CYC,
    parameter int unsigned REF_SETTLE_CYCLES  = PMC_REF_SETTLE_CYC
) (
    // clock and resets
    input  wire logic        ref_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        por_rst_in,
    input  wire logic        rst_protect_in,
    // register port
    input  wire logic [11:0] reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [31:0] reg_rdata_out,
    // device events
    input  wire logic        phy_reset_req_in,
    input  wire logic        config_loading_in,
    input  wire logic        eee_wake_event_in,
    input  wire logic        resume_done_in,
    input  wire logic        resume_remote_in,
    input  wire logic        osc_off_req_in,
    // mac clock status from the mac domains
    input  wire logic        mac_rx_clk_running_in,
    input  wire logic        mac_tx_clk_running_in,
    // controls out
    output logic             phy_reset_out,
    output logic             ana_ref_enable_out,
    output logic             crystal_enable_out,
    output logic             eee_wake_request_out,
    output logic             wake_status_clear_out,
    output logic             wake_enable_clear_out,
    output logic             mac_rx_reset_out,
    output logic             mac_tx_reset_out
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    initial begin
        if (NETWORK_PHY_RESET_MIN_CYCLES < 1 || NETWORK_PHY_RESET_EXT_CYCLES < NETWORK_PHY_RESET_MIN_CYCLES ||
            NETWORK_PHY_RESET_EXT_CYCLES >= (1 << PMC_PHY_CNT_W) ||
            REF_SETTLE_CYCLES > NETWORK_PHY_RESET_EXT_CYCLES) begin
            $error("pmc_power_mgmt_control: unusable reset timing parameters");
        end
    end

    localparam logic [PMC_PHY_CNT_W-1:0] MIN_LAST =
        PMC_PHY_CNT_W'(NETWORK_PHY_RESET_MIN_CYCLES - 1);
    localparam logic [PMC_PHY_CNT_W-1:0] EXT_LAST =
        PMC_PHY_CNT_W'(NETWORK_PHY_RESET_EXT_CYCLES - 1);
    localparam logic [PMC_PHY_CNT_W-1:0] REF_OFF_END =
        PMC_PHY_CNT_W'(NETWORK_PHY_RESET_EXT_CYCLES - REF_SETTLE_CYCLES);

    function automatic logic reg_hit(input logic [11:0] addr);
        reg_hit = (addr == PMC_CTL_OFFSET);
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic                     ref_wait_dis_q;
    logic                     crystal_suspend_disable_q;
    logic                     eee_wake_en_q;
    logic                     eee_wake_sts_q;
    logic                     mac_soft_rst_q;
    logic                     res_clr_sts_q;
    logic                     res_clr_en_q;
    logic                     dev_ready_q;
    logic                     network_phy_reset_q;
    logic                     ref_mode_q;
    logic [PMC_PHY_CNT_W-1:0] phy_cnt_q;
    logic                     ana_ref_q;
    logic                     xtal_en_q;
    logic                     eee_req_q;
    logic                     sts_clr_q;
    logic                     en_clr_q;
    logic                     rx_run_s1_q;
    logic                     rx_run_s2_q;
    logic                     tx_run_s1_q;
    logic                     tx_run_s2_q;
    logic                     mac_rx_rst_q;
    logic                     mac_tx_rst_q;
    logic [31:0]              rdata_q;

    logic wr_hit;
    logic remote_resume;
    logic phy_done;
    logic protect_rst;

    assign wr_hit        = reg_wr_in && reg_hit(reg_addr_in);
    assign remote_resume = resume_done_in && resume_remote_in;
    assign phy_done      = network_phy_reset_q && (phy_cnt_q == (ref_mode_q ? MIN_LAST : EXT_LAST));
    assign protect_rst   = por_rst_in || (sys_rst_in && !rst_protect_in);

    // ------------------------------------------------------------------
    // protected configuration bits
    // ------------------------------------------------------------------
    // reset protection
    always_ff @(posedge ref_clk_in) begin
        if (protect_rst) begin
            ref_wait_dis_q  <= PMC_REF_WAIT_DIS_RST;
            crystal_suspend_disable_q <= PMC_CRYSTAL_SUSPEND_DISABLE_RST;
        end else if (wr_hit) begin
            ref_wait_dis_q  <= reg_wdata_in[PMC_REF_WAIT_DIS_BIT];
            crystal_suspend_disable_q <= reg_wdata_in[PMC_CRYSTAL_SUSPEND_DISABLE_BIT];
        end
    end

    // ------------------------------------------------------------------
    // plain control bits
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            mac_soft_rst_q <= PMC_MAC_SOFT_RST_RST;
            res_clr_sts_q  <= PMC_RES_CLR_STS_RST;
            res_clr_en_q   <= PMC_RES_CLR_EN_RST;
        end else if (wr_hit) begin
            mac_soft_rst_q <= reg_wdata_in[PMC_MAC_SOFT_RST_BIT];
            res_clr_sts_q  <= reg_wdata_in[PMC_RES_CLR_STS_BIT];
            res_clr_en_q   <= reg_wdata_in[PMC_RES_CLR_EN_BIT];
        end
    end

    // ------------------------------------------------------------------
    // eee wake enable and status
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            eee_wake_en_q <= PMC_EEE_WAKE_EN_RST;
        end else if (remote_resume && res_clr_en_q) begin
            eee_wake_en_q <= 1'b0;
        end else if (wr_hit) begin
            eee_wake_en_q <= reg_wdata_in[PMC_EEE_WAKE_EN_BIT];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            eee_wake_sts_q <= PMC_EEE_WAKE_STS_RST;
        end else if (eee_wake_event_in) begin
            eee_wake_sts_q <= 1'b1;
        end else if (remote_resume && res_clr_sts_q) begin
            eee_wake_sts_q <= 1'b0;
        end else if (wr_hit && reg_wdata_in[PMC_EEE_WAKE_STS_BIT]) begin
            eee_wake_sts_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            eee_req_q <= 1'b0;
        end else begin
            eee_req_q <= eee_wake_sts_q && eee_wake_en_q;
        end
    end

    // ------------------------------------------------------------------
    // resume side effects on the wake control registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            sts_clr_q <= 1'b0;
            en_clr_q  <= 1'b0;
        end else begin
            sts_clr_q <= remote_resume && res_clr_sts_q;
            en_clr_q  <= remote_resume && res_clr_en_q;
        end
    end

    // ------------------------------------------------------------------
    // phy reset timer and analog reference
    // ------------------------------------------------------------------
    // minimum and stretched hold
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            network_phy_reset_q  <= 1'b0;
            ref_mode_q <= 1'b0;
            phy_cnt_q  <= '0;
        end else if (!network_phy_reset_q) begin
            if (phy_reset_req_in) begin
                network_phy_reset_q  <= 1'b1;
                ref_mode_q <= ref_wait_dis_q;
                phy_cnt_q  <= '0;
            end
        end else if (phy_done) begin
            network_phy_reset_q <= 1'b0;
            phy_cnt_q <= '0;
        end else begin
            phy_cnt_q <= phy_cnt_q + 1'b1;
        end
    end

    // reference off only without wait disable
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            ana_ref_q <= 1'b1;
        end else begin
            ana_ref_q <= !(network_phy_reset_q && !ref_mode_q && (phy_cnt_q < REF_OFF_END));
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            xtal_en_q <= 1'b1;
        end else begin
            xtal_en_q <= crystal_suspend_disable_q || !osc_off_req_in;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            dev_ready_q <= PMC_DEV_READY_RST;
        end else begin
            dev_ready_q <= !network_phy_reset_q && !phy_reset_req_in && !config_loading_in;
        end
    end

    // ------------------------------------------------------------------
    // mac domain resets
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            rx_run_s1_q <= 1'b0;
            rx_run_s2_q <= 1'b0;
            tx_run_s1_q <= 1'b0;
            tx_run_s2_q <= 1'b0;
        end else begin
            rx_run_s1_q <= mac_rx_clk_running_in;
            rx_run_s2_q <= rx_run_s1_q;
            tx_run_s1_q <= mac_tx_clk_running_in;
            tx_run_s2_q <= tx_run_s1_q;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            mac_rx_rst_q <= 1'b1;
            mac_tx_rst_q <= 1'b1;
        end else begin
            mac_rx_rst_q <= mac_soft_rst_q || (mac_rx_rst_q && !rx_run_s2_q);
            mac_tx_rst_q <= mac_soft_rst_q || (mac_tx_rst_q && !tx_run_s2_q);
        end
    end

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    // reserved bits read zero
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            rdata_q <= 32'h0000_0000;
        end else if (reg_rd_in && reg_hit(reg_addr_in)) begin
            rdata_q <= 32'h0000_0000;
            rdata_q[PMC_REF_WAIT_DIS_BIT]  <= ref_wait_dis_q;
            rdata_q[PMC_CRYSTAL_SUSPEND_DISABLE_BIT] <= crystal_suspend_disable_q;
            rdata_q[PMC_EEE_WAKE_EN_BIT]   <= eee_wake_en_q;
            rdata_q[PMC_EEE_WAKE_STS_BIT]  <= eee_wake_sts_q;
            rdata_q[PMC_MAC_SOFT_RST_BIT]  <= mac_soft_rst_q;
            rdata_q[PMC_RES_CLR_STS_BIT]   <= res_clr_sts_q;
            rdata_q[PMC_RES_CLR_EN_BIT]    <= res_clr_en_q;
            rdata_q[PMC_DEV_READY_BIT]     <= dev_ready_q;
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    assign reg_rdata_out         = rdata_q;
    assign phy_reset_out         = network_phy_reset_q;
    assign ana_ref_enable_out    = ana_ref_q;
    assign crystal_enable_out    = xtal_en_q;
    assign eee_wake_request_out  = eee_req_q;
    assign wake_status_clear_out = sts_clr_q;
    assign wake_enable_clear_out = en_clr_q;
    assign mac_rx_reset_out      = mac_rx_rst_q;
    assign mac_tx_reset_out      = mac_tx_rst_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    ref_kept_on_a: assert property (
        network_phy_reset_q && ref_mode_q |=> ana_ref_q)
        else $error("analog reference dropped with wait disable set");

    protect_hold_a: assert property (disable iff (por_rst_in)
        sys_rst_in && rst_protect_in && !wr_hit |=> $stable(ref_wait_dis_q) &&
        $stable(crystal_suspend_disable_q))
        else $error("protected bits lost on protected reset");

    xtal_on_a: assert property (
        crystal_suspend_disable_q && osc_off_req_in |=> xtal_en_q)
        else $error("crystal stopped while suspend disable set");

    eee_request_a: assert property (
        eee_wake_sts_q && eee_wake_en_q |=> eee_req_q)
        else $error("eee wake request missing");

    en_autoclr_a: assert property (
        remote_resume && res_clr_en_q |=> !eee_wake_en_q ##0 en_clr_q)
        else $error("wake enable not cleared on remote resume");

    eee_set_a: assert property (
        eee_wake_event_in |=> eee_wake_sts_q)
        else $error("eee wake status not set");

    wc_clear_a: assert property (
        wr_hit && reg_wdata_in[PMC_EEE_WAKE_STS_BIT] && !eee_wake_event_in |=>
        !eee_wake_sts_q)
        else $error("eee wake status not cleared by write");

    mac_hold_a: assert property (
        mac_soft_rst_q |=> mac_rx_rst_q && mac_tx_rst_q)
        else $error("mac domains not held in reset");

    mac_release_a: assert property (
        $fell(mac_rx_rst_q) || $fell(mac_tx_rst_q) |->
        ($fell(mac_rx_rst_q) ? $past(rx_run_s2_q) : $past(tx_run_s2_q)))
        else $error("mac reset released without running clock");

    sts_pulse_a: assert property (
        sts_clr_q |-> $past(remote_resume && res_clr_sts_q))
        else $error("status clear without remote resume");

    host_resume_a: assert property (
        resume_done_in && !resume_remote_in && !wr_hit && !eee_wake_event_in |=>
        $stable(eee_wake_sts_q) && $stable(eee_wake_en_q) && !sts_clr_q && !en_clr_q)
        else $error("host resume touched wake state");

    no_clr_a: assert property (
        resume_done_in && !res_clr_sts_q |=> !sts_clr_q)
        else $error("status cleared with clear policy off");

    ready_low_a: assert property (
        network_phy_reset_q || config_loading_in |=> !dev_ready_q)
        else $error("device ready during reset or load");

    min_hold_a: assert property (
        $fell(network_phy_reset_q) |-> $past(phy_cnt_q) == ($past(ref_mode_q) ? MIN_LAST : EXT_LAST))
        else $error("phy reset released early");

    rsv_zero_a: assert property (
        rdata_q[31:16] == 16'h0000 && rdata_q[10] == 1'b0)
        else $error("reserved bits read nonzero");

endmodule

// *** tb/pmc_power_mgmt_control_tb.sv ***
`timescale 1ns/1ps
module pmc_power_mgmt_control_tb
    import pmc_pkg::*;
;
    localparam int MIN_C = 8;
    localparam int EXT_C = 32;
    localparam int SET_C = 20;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        por = 1'b1;
    logic        prot = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata;
    logic        preq = 1'b0;
    logic        cfg = 1'b0;
    logic        eee = 1'b0;
    logic        rdone = 1'b0;
    logic        rremote = 1'b0;
    logic        osc = 1'b0;
    logic        rxrun = 1'b1;
    logic        txrun = 1'b1;
    logic        phy, ana, xtal, ereq, sclr, eclr, rxr, txr;
    int          fails = 0;
    int          checks = 0;
    int          n;
    logic        ana_low;
    logic [31:0] v;

    always #5 clk = ~clk;

    pmc_power_mgmt_control #(
        .NETWORK_PHY_RESET_MIN_CYCLES(MIN_C),
        .NETWORK_PHY_RESET_EXT_CYCLES(EXT_C),
        .REF_SETTLE_CYCLES (SET_C)
    ) u_dut (
        .ref_clk_in           (clk),
        .sys_rst_in           (rst),
        .por_rst_in           (por),
        .rst_protect_in       (prot),
        .reg_addr_in          (addr),
        .reg_wdata_in         (wdata),
        .reg_wr_in            (wr),
        .reg_rd_in            (rd),
        .reg_rdata_out        (rdata),
        .phy_reset_req_in     (preq),
        .config_loading_in    (cfg),
        .eee_wake_event_in    (eee),
        .resume_done_in       (rdone),
        .resume_remote_in     (rremote),
        .osc_off_req_in       (osc),
        .mac_rx_clk_running_in(rxrun),
        .mac_tx_clk_running_in(txrun),
        .phy_reset_out        (phy),
        .ana_ref_enable_out   (ana),
        .crystal_enable_out   (xtal),
        .eee_wake_request_out (ereq),
        .wake_status_clear_out(sclr),
        .wake_enable_clear_out(eclr),
        .mac_rx_reset_out     (rxr),
        .mac_tx_reset_out     (txr)
    );

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
        #1;
    endtask

    task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic rd_chk(input string name, input logic [31:0] exp);
        logic [31:0] d;
        rd_reg(PMC_CTL_OFFSET, d);
        chk(name, exp, d);
    endtask

    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (5) @(posedge clk);
    endtask

    task automatic eee_pulse();
        @(posedge clk);
        eee <= 1'b1;
        @(posedge clk);
        eee <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic resume(input logic remote, input logic exp_s, input logic exp_e);
        @(posedge clk);
        rdone   <= 1'b1;
        rremote <= remote;
        @(posedge clk);
        rdone   <= 1'b0;
        #1;
        chk("status_clear_pulse", exp_s, sclr);
        chk("enable_clear_pulse", exp_e, eclr);
    endtask

    task automatic phy_run(output int cnt, output logic saw_low);
        @(posedge clk);
        preq <= 1'b1;
        @(posedge clk);
        preq <= 1'b0;
        #1;
        cnt = 0;
        saw_low = 1'b0;
        while (phy === 1'b1 && cnt < 1000) begin
            cnt++;
            if (ana !== 1'b1) saw_low = 1'b1;
            @(posedge clk);
            #1;
        end
    endtask

    task automatic stop_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        fails++;
        stop_test();
    end

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        por <= 1'b0;
        repeat (5) @(posedge clk);
        rd_chk("reset_value", 32'h0000_0180);
        chk("mac_rx_reset", 1'b0, rxr);
        chk("ana_ref_idle", 1'b1, ana);
        $display("test reset_values done");

        wr_reg(PMC_CTL_OFFSET, 32'hffff_ffff);
        rd_chk("all_ones", 32'h0000_eb80);
        chk("mac_rx_held", 1'b1, rxr);
        chk("mac_tx_held", 1'b1, txr);
        wr_reg(12'h018, 32'h0000_0000);
        rd_chk("unmapped_write", 32'h0000_eb80);
        rd_reg(12'h018, v);
        chk("unmapped_read", 32'h0, v);
        @(posedge clk);
        osc <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("crystal_kept", 1'b1, xtal);
        wr_reg(PMC_CTL_OFFSET, 32'h0000_0100);
        repeat (3) @(posedge clk);
        #1;
        chk("crystal_off", 1'b0, xtal);
        @(posedge clk);
        osc <= 1'b0;
        $display("test access done");

        wr_reg(PMC_CTL_OFFSET, 32'h0000_0900);
        @(posedge clk);
        #1;
        chk("mac_rx_set", 1'b1, rxr);
        @(posedge clk);
        rxrun <= 1'b0;
        repeat (3) @(posedge clk);
        wr_reg(PMC_CTL_OFFSET, 32'h0000_0100);
        repeat (8) @(posedge clk);
        #1;
        chk("mac_rx_no_clock", 1'b1, rxr);
        chk("mac_tx_released", 1'b0, txr);
        @(posedge clk);
        rxrun <= 1'b1;
        repeat (5) @(posedge clk);
        #1;
        chk("mac_rx_released", 1'b0, rxr);
        $display("test mac_reset done");

        wr_reg(PMC_CTL_OFFSET, 32'h0000_2300);
        eee_pulse();
        chk("eee_request", 1'b1, ereq);
        rd_chk("eee_status_set", 32'h0000_3380);
        resume(1'b0, 1'b0, 1'b0);
        rd_chk("host_resume", 32'h0000_3380);
        resume(1'b1, 1'b1, 1'b1);
        rd_chk("remote_resume", 32'h0000_0380);
        wr_reg(PMC_CTL_OFFSET, 32'h0000_2000);
        eee_pulse();
        resume(1'b1, 1'b0, 1'b0);
        rd_chk("no_clear_policy", 32'h0000_3080);
        wr_reg(PMC_CTL_OFFSET, 32'h0000_1000);
        rd_chk("status_cleared", 32'h0000_0080);
        eee_pulse();
        chk("eee_request_off", 1'b0, ereq);
        rd_chk("status_no_enable", 32'h0000_1080);
        $display("test resume done");

        wr_reg(PMC_CTL_OFFSET, 32'h0000_8000);
        phy_run(n, ana_low);
        chk("phy_hold_min", MIN_C, n);
        chk("ana_kept", 1'b0, ana_low);
        wr_reg(PMC_CTL_OFFSET, 32'h0000_0000);
        phy_run(n, ana_low);
        chk("phy_hold_ext", EXT_C, n);
        chk("ana_dropped", 1'b1, ana_low);
        @(posedge clk);
        preq <= 1'b1;
        @(posedge clk);
        preq <= 1'b0;
        // eee status is still pending from the no-enable test
        rd_chk("ready_in_phy_reset", 32'h0000_1000);
        n = 0;
        while (phy !== 1'b0 && n < 1000) begin
            @(posedge clk);
            #1;
            n++;
        end
        repeat (3) @(posedge clk);
        rd_chk("ready_after_phy", 32'h0000_1080);
        @(posedge clk);
        cfg <= 1'b1;
        repeat (3) @(posedge clk);
        rd_chk("ready_in_config", 32'h0000_1000);
        @(posedge clk);
        cfg <= 1'b0;
        repeat (3) @(posedge clk);
        $display("test phy_reset done");

        wr_reg(PMC_CTL_OFFSET, 32'h0000_c000);
        @(posedge clk);
        prot <= 1'b1;
        do_reset();
        rd_chk("protected_bits", 32'h0000_c180);
        @(posedge clk);
        prot <= 1'b0;
        do_reset();
        rd_chk("unprotected_bits", 32'h0000_0180);
        $display("test protection done");
        stop_test();
    end
endmodule
